// File: common/scr_pkg.sv
/*
  Package for the system control register bank: offsets, field positions,
  reset values and carrier structs.
  Assumes a byte-wide register space reached over a 32-bit Avalon-MM slave.
*/
package scr_pkg;

  // Printed offsets; not all multiples of four, so byte address = index * 4
  localparam logic [23:0] SCR_IDX_BUS_MODE = 24'h00FF00;
  localparam logic [23:0] SCR_IDX_STACK_PAGE = 24'h00FF01;
  localparam logic [23:0] SCR_IDX_CLK_VOLT = 24'h00FF02;
  localparam logic [23:0] SCR_IDX_DISP_CFG = 24'h00FF10;
  localparam int SCR_ADDR_W = 26;

  // Field positions
  localparam int SCR_CLK_SRC_BIT = 3;
  localparam int SCR_FAST_OSC_BIT = 2;
  localparam int SCR_VOLT_HI_BIT = 1;
  localparam int SCR_VOLT_LO_BIT = 0;
  localparam int SCR_FONT_BIT = 2;
  localparam int SCR_DUTY_BIT = 1;

  // Reset values
  localparam logic [7:0] SCR_RST_BUS_MODE = 8'h30;
  localparam logic [7:0] SCR_RST_STACK_PAGE = 8'h00;
  localparam logic [7:0] SCR_RST_CLK_VOLT = 8'h00;
  localparam logic [7:0] SCR_RST_DISP_CFG = 8'h00;
  localparam logic [7:0] SCR_DISP_CFG_MASK = 8'h1F;

  // Bus answer timing: one wait cycle before the access completes
  localparam int SCR_WAIT_CYCLES = 1;

  typedef enum logic [1:0] {
    SCR_VM_NORMAL,
    SCR_VM_LOW_POWER,
    SCR_VM_HIGH_SPEED
  } scr_volt_mode_e;

  typedef struct packed {
    logic cpu_clock_source_select;
    logic fast_oscillator_on;
    scr_volt_mode_e volt_mode;
  } scr_clock_ctl_s;

  typedef struct packed {
    logic character_font_select;
    logic drive_duty_select;
  } scr_display_ctl_s;

endpackage

// File: verilog/scr_decode.sv
/*
  Address decoder for the register bank: maps a word address to a one-hot
  register select, flagging unmapped addresses.
  Assumes the word address is already stripped of byte-lane bits.
*/
`timescale 1ns/10ps
`default_nettype none

module scr_decode
  import scr_pkg::*;
(
  // Word address
  input wire logic [23:0] word_addr,
  // Register selects
  output logic [3:0] sel,
  output logic hit
);

  always_comb begin
    sel = 4'h0;
    unique case (word_addr)
      SCR_IDX_BUS_MODE: sel = 4'h1;
      SCR_IDX_STACK_PAGE: sel = 4'h2;
      SCR_IDX_CLK_VOLT: sel = 4'h4;
      SCR_IDX_DISP_CFG: sel = 4'h8;
      default: sel = 4'h0;
    endcase
    hit = |sel;
  end

endmodule
`default_nettype wire

// File: verilog/scr_bank.sv
/*
  System control register bank: general-purpose bits, CPU clock source,
  fast oscillator enable, voltage mode and display font and duty.
  Assumes an Avalon-MM master on clock; one clock, synchronous reset.
*/
// The Avalon-MM slave port was chosen for this implementation.
// Function
// - Clock source bit D3: 1 runs CPU from fast, 0 slow; resets 0.
// - Fast oscillator run bit D2: 1 on, 0 off; resets 0.
// - Voltage mode: high bit set gives high speed, 01 low power, 00 normal.
// - Font bit D2 of display register: 1 five by five, 0 five by eight.
// - Duty bit D1: 1 gives 1/16 duty, 0 gives 1/32; resets 0.
// - Fixed 1/8 duty option makes the duty bit have no effect.
`timescale 1ns/10ps
`default_nettype none

module scr_bank
  import scr_pkg::*;
#(
  parameter bit FIXED_EIGHTH_DUTY = 1'b0,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [SCR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W/8-1:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Control outputs
  output scr_clock_ctl_s clock_ctl,
  output scr_display_ctl_s display_ctl,
  output logic duty_eighth,
  output logic [7:0] bus_mode_bits,
  output logic [7:0] stack_page_bits
);

  if (DATA_W != 32) begin : g_width_check
    $error("scr_bank supports only 32-bit data");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic [3:0] sel;
  logic hit;

  scr_decode u_dec (
    .word_addr(avs_address[SCR_ADDR_W-1:2]),
    .sel(sel),
    .hit(hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: first cycle waits, second completes

  logic wait_done_q, wait_done_d;
  logic access;
  logic done;
  logic wr_en;

  assign access = avs_read | avs_write;
  // Completion only on an enabled edge, so a frozen cycle keeps waiting
  assign done = access & wait_done_q & clk_en;
  assign avs_waitrequest = access & ~done;
  assign wr_en = done & avs_write & avs_byteenable[0];

  always_comb begin
    wait_done_d = wait_done_q;
    if (clk_en) begin
      wait_done_d = access & ~wait_done_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wait_done_q <= 1'b0;
    end else begin
      wait_done_q <= wait_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] regs_q [4];
  logic [7:0] regs_d [4];
  logic [7:0] rst_val [4];
  logic [7:0] wr_mask [4];

  assign rst_val[0] = SCR_RST_BUS_MODE;
  assign rst_val[1] = SCR_RST_STACK_PAGE;
  assign rst_val[2] = SCR_RST_CLK_VOLT;
  assign rst_val[3] = SCR_RST_DISP_CFG;
  assign wr_mask[0] = 8'hFF;
  assign wr_mask[1] = 8'hFF;
  assign wr_mask[2] = 8'hFF;
  assign wr_mask[3] = SCR_DISP_CFG_MASK;

  for (genvar i = 0; i < 4; i++) begin : g_reg
    always_comb begin
      regs_d[i] = regs_q[i];
      if (clk_en && wr_en && sel[i]) begin
        regs_d[i] = avs_writedata[7:0] & wr_mask[i];
      end
    end

    always_ff @(posedge clock) begin
      if (reset) begin
        regs_q[i] <= rst_val[i];
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and response

  logic [7:0] rd_byte;
  logic [DATA_W-1:0] readdata_q, readdata_d;
  logic [1:0] resp_q, resp_d;

  always_comb begin
    rd_byte = 8'h00;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        rd_byte = regs_q[k] & wr_mask[k];
      end
    end
  end

  always_comb begin
    readdata_d = readdata_q;
    resp_d = resp_q;
    if (clk_en && access && !wait_done_q) begin
      readdata_d = {24'h000000, rd_byte};
      resp_d = hit ? 2'h0 : 2'h3;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      readdata_q <= '0;
      resp_q <= 2'h0;
    end else begin
      readdata_q <= readdata_d;
      resp_q <= resp_d;
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_response = resp_q;

  ////////////////////////////////////////////////////////////////////////
  // Control decode

  logic [7:0] cv;
  logic [7:0] dc;
  assign cv = regs_q[2];
  assign dc = regs_q[3];

  assign clock_ctl.cpu_clock_source_select = cv[SCR_CLK_SRC_BIT];
  assign clock_ctl.fast_oscillator_on = cv[SCR_FAST_OSC_BIT];

  always_comb begin
    if (cv[SCR_VOLT_HI_BIT]) begin
      clock_ctl.volt_mode = SCR_VM_HIGH_SPEED;
    end else if (cv[SCR_VOLT_LO_BIT]) begin
      clock_ctl.volt_mode = SCR_VM_LOW_POWER;
    end else begin
      clock_ctl.volt_mode = SCR_VM_NORMAL;
    end
  end

  assign display_ctl.character_font_select = dc[SCR_FONT_BIT];
  // duty select, overridden by fixed option
  assign display_ctl.drive_duty_select = FIXED_EIGHTH_DUTY ? 1'b0 : dc[SCR_DUTY_BIT];
  assign duty_eighth = FIXED_EIGHTH_DUTY;
  assign bus_mode_bits = regs_q[0];
  assign stack_page_bits = regs_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_clk_src;
    @(posedge clock) disable iff (reset)
      (wr_en && clk_en && sel[2]) |=> (clock_ctl.cpu_clock_source_select == $past(avs_writedata[3]));
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source not updated");

  property p_fast_osc;
    @(posedge clock) disable iff (reset)
      (wr_en && clk_en && sel[2]) |=> (clock_ctl.fast_oscillator_on == $past(avs_writedata[2]));
  endproperty
  a_fast_osc: assert property (p_fast_osc) else $error("fast oscillator bit wrong");

  property p_volt;
    @(posedge clock) disable iff (reset)
      cv[1] |-> clock_ctl.volt_mode == SCR_VM_HIGH_SPEED;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage mode decode wrong");

  property p_font;
    @(posedge clock) disable iff (reset)
      (wr_en && clk_en && sel[3]) |=> (display_ctl.character_font_select == $past(avs_writedata[2]));
  endproperty
  a_font: assert property (p_font) else $error("font bit wrong");

  property p_duty;
    @(posedge clock) disable iff (reset)
      (!FIXED_EIGHTH_DUTY && wr_en && clk_en && sel[3])
        |=> (display_ctl.drive_duty_select == $past(avs_writedata[1]));
  endproperty
  a_duty: assert property (p_duty) else $error("duty bit wrong");

  property p_fixed;
    @(posedge clock) disable iff (reset)
      FIXED_EIGHTH_DUTY |-> !display_ctl.drive_duty_select;
  endproperty
  a_fixed: assert property (p_fixed) else $error("duty select active under fixed option");

  property p_unimpl;
    @(posedge clock) disable iff (reset)
      (done && avs_read && sel[3]) |-> avs_readdata[7:5] == 3'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero");

  property p_wait;
    @(posedge clock) disable iff (reset)
      (access && !wait_done_q && clk_en) |=> (!(access && clk_en) || !avs_waitrequest);
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held too long");

endmodule
`default_nettype wire

// File: verif/scr_bank_tb.sv
/*
  Testbench for scr_bank: a byte-array model checked at every access.
  Assumes an Avalon-MM slave with waitrequest; a second instance has the fixed duty option.
*/
`timescale 1ns/10ps
`default_nettype none

module scr_bank_tb;
  import scr_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  bit rnd_en = 1'b0;
  scr_display_ctl_s display_ctl_fx;
  logic duty_eighth_fx;
  logic [SCR_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  scr_clock_ctl_s clock_ctl;
  scr_display_ctl_s display_ctl;
  logic duty_eighth;
  logic [7:0] bus_mode_bits;
  logic [7:0] stack_page_bits;
  logic [23:0] idx [5] = '{SCR_IDX_BUS_MODE, SCR_IDX_STACK_PAGE, SCR_IDX_CLK_VOLT,
                           SCR_IDX_DISP_CFG, 24'h00FF03};
  logic [7:0] m [4];
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  always #2 clock = ~clock;

  // Random freezes during the random phase
  always @(posedge clock) clk_en <= !rnd_en || ($urandom_range(0, 3) != 0);

  scr_bank #(.FIXED_EIGHTH_DUTY(1'b1)) i_scr_bank_fixed (.clock(clock), .reset(reset),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .avs_response(), .clock_ctl(), .display_ctl(display_ctl_fx),
    .duty_eighth(duty_eighth_fx), .bus_mode_bits(), .stack_page_bits());

  scr_bank i_scr_bank (.clock(clock), .reset(reset), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .clock_ctl(clock_ctl), .display_ctl(display_ctl),
    .duty_eighth(duty_eighth), .bus_mode_bits(bus_mode_bits),
    .stack_page_bits(stack_page_bits));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic outs();
    chk(bus_mode_bits, m[0]);
    chk(stack_page_bits, m[1]);
    chk(clock_ctl.cpu_clock_source_select, m[2][3]);
    chk(clock_ctl.fast_oscillator_on, m[2][2]);
    chk(clock_ctl.volt_mode, m[2][1] ? 2 : {1'b0, m[2][0]});
    chk(display_ctl.character_font_select, m[3][2]);
    chk(display_ctl.drive_duty_select, m[3][1]);
    chk(duty_eighth, 0);
    chk(display_ctl_fx.character_font_select, m[3][2]);
    chk(display_ctl_fx.drive_duty_select, 0);
    chk(duty_eighth_fx, 1);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input bit wr, input int k, input logic [7:0] wd,
                     input logic [3:0] be);
    int n;
    logic [31:0] rd;
    logic [1:0] rs;
    n = 0;
    avs_address <= {idx[k], 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'($urandom), wd};
    avs_byteenable <= be;
    do begin
      @(posedge clock);
      n++;
      if (n == 1)
        outs();
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // spare bits store, display top bits dropped
    if (wr && k < 4 && be[0])
      m[k] = (k == 3) ? (wd & SCR_DISP_CFG_MASK) : wd;
    chk(rs, (k < 4) ? 2'h0 : 2'h3);
    if (!wr)
      chk(rd, (k < 4) ? {24'h0, m[k]} : 32'h0);
    @(posedge clock);
  endtask

  task automatic rst();
    @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    m = '{SCR_RST_BUS_MODE, SCR_RST_STACK_PAGE, SCR_RST_CLK_VOLT, SCR_RST_DISP_CFG};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hf6d83c26));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    m = '{SCR_RST_BUS_MODE, SCR_RST_STACK_PAGE, SCR_RST_CLK_VOLT, SCR_RST_DISP_CFG};
    for (int k = 0; k < 5; k++)
      bus(0, k, 8'h00, 4'h1);
    for (int k = 0; k < 5; k++) begin
      for (int b = 0; b < 8; b++) begin
        bus(1, k, 8'h01 << b, 4'hF);
        bus(0, k, 8'h00, 4'hF);
      end
    end
    bus(1, 2, 8'h03, 4'h1);
    rnd_en = 1'b1;
    repeat (200)
      bus(1'($urandom), $urandom_range(0, 4), 8'($urandom), 4'($urandom));
    rnd_en = 1'b0;
    rst();
    for (int k = 0; k < 5; k++)
      bus(0, k, 8'h00, 4'h1);
    test_done();
  end
endmodule

`default_nettype wire
